// >>> rtl/line_ctrl_regs.sv
`timescale 1ns/1ps
module line_ctrl_regs (
  input wire logic CLK, // 100 MHz system clock
  input wire logic RST_N, // Async reset, active low
  input wire logic [7:0] ADDR, // Control port address
  input wire logic WR_EN, // Write strobe, one cycle
  input wire logic RD_EN, // Read strobe, one cycle
  input wire logic [7:0] WDATA, // Write data
  output logic [7:0] RDATA, // Read data, registered
  output logic RD_VALID, // Read data valid pulse
  input wire logic [1:0] LINE_MODE, // Network mode, line_mode_t
  input wire logic BIT_TICK, // One-cycle transmit bit enable
  input wire logic TX_DATA, // Transmit data bit, unipolar
  output logic TX_LINE_POS_O, // Positive line output
  output logic TX_LINE_POS_OE_N, // Positive line enable, low drives
  output logic TX_LINE_NEG_O, // Negative line output
  output logic TX_LINE_NEG_OE_N, // Negative line enable, low drives
  output logic ATTEN_ENABLE, // Attenuator in path
  output logic [7:0] ATTEN_DEPTH, // Elastic store depth in bits
  output logic ATTEN_ON_TX, // Attenuator on transmit side
  output logic EQ_GAIN_LIMIT, // Receive equalizer limit
  output logic [2:0] BUILD_OUT, // Build-out code
  output logic AUTO_GAIN_ON, // Transmit automatic gain active
  output logic [5:0] GAIN_LEVEL, // Fixed gain level
  output logic SHORT_LIMIT_EN, // Current limiter active
  output logic CC_FILTER_EN, // 64 kHz recovered clock filter on
  output logic PLL_T1_EN, // 2.048 to 1.544 MHz PLL on
  output logic PLL_E1_EN, // 12.8 to 2.048 MHz PLL on
  output logic [1:0] MONITOR_BOOST, // Receive gain boost code
  output logic CMI_EN, // Mark-inversion coding on
  output logic CMI_INV, // Mark-inversion invert
  output logic LINE_RESET_PULSE // Recovery reset, recenter pulse
);

  // Stored registers
  logic [7:0] line_cfg_one_reg; // Build-out, attenuator, power
  logic [7:0] line_cfg_two_reg; // Clocks, alarms, reset
  logic [7:0] line_cfg_three_reg; // Pattern, monitor, coding
  logic [7:0] tx_build_out_gain_reg; // Gain control

  // Address decode
  wire sel_one = (ADDR == line_ctrl_pkg::OFS_LINE_CFG_ONE);
  wire sel_two = (ADDR == line_ctrl_pkg::OFS_LINE_CFG_TWO);
  wire sel_three = (ADDR == line_ctrl_pkg::OFS_LINE_CFG_THREE);
  wire sel_gain = (ADDR == line_ctrl_pkg::OFS_TX_BUILD_OUT_GAIN);

  // Read mux, unmapped reads as zero
  wire [7:0] rd_mux = sel_one ? line_cfg_one_reg :
                      sel_two ? line_cfg_two_reg :
                      sel_three ? line_cfg_three_reg :
                      sel_gain ? tx_build_out_gain_reg :
                      line_ctrl_pkg::RD_UNMAPPED;

  // Field views
  wire power_n = line_cfg_one_reg[line_ctrl_pkg::POS_TX_POWER_DOWN_N];
  wire atten_disable = line_cfg_one_reg[line_ctrl_pkg::POS_ATTEN_DISABLE];
  wire atten_depth_sel = line_cfg_one_reg[line_ctrl_pkg::POS_ATTEN_DEPTH_SEL];
  wire atten_side_sel = line_cfg_one_reg[line_ctrl_pkg::POS_ATTEN_SIDE_SEL];
  wire eq_gain_limit = line_cfg_one_reg[line_ctrl_pkg::POS_EQ_GAIN_LIMIT];
  wire [2:0] build_out =
    line_cfg_one_reg[line_ctrl_pkg::POS_BUILD_OUT_MSB:line_ctrl_pkg::POS_BUILD_OUT_LSB];
  wire custom_driver_sel = line_cfg_two_reg[line_ctrl_pkg::POS_CUSTOM_DRIVER_SEL];
  wire short_limit_off = line_cfg_two_reg[line_ctrl_pkg::POS_SHORT_LIMIT_OFF];
  wire cc_filter_bit = line_cfg_two_reg[line_ctrl_pkg::POS_RX_COMP_CLK_FILTER_EN];
  wire atten_clk_sel_lo = line_cfg_two_reg[line_ctrl_pkg::POS_ATTEN_CLK_SEL_LO];
  wire tx_alarm_ones_n = line_cfg_two_reg[line_ctrl_pkg::POS_TX_ALARM_ONES_N];
  wire insert_violation = line_cfg_two_reg[line_ctrl_pkg::POS_INSERT_VIOLATION];
  wire line_soft_reset = line_cfg_two_reg[line_ctrl_pkg::POS_LINE_SOFT_RESET];
  wire atten_clk_sel_hi = line_cfg_two_reg[line_ctrl_pkg::POS_ATTEN_CLK_SEL_HI];
  wire alt_pattern = line_cfg_three_reg[line_ctrl_pkg::POS_TX_ALTERNATING_PATTERN];
  wire [1:0] monitor_gain =
    line_cfg_three_reg[line_ctrl_pkg::POS_MONITOR_GAIN_HI:line_ctrl_pkg::POS_MONITOR_GAIN_LO];
  wire cmi_inv_bit = line_cfg_three_reg[line_ctrl_pkg::POS_MARK_INVERSION_INVERT];
  wire cmi_en_bit = line_cfg_three_reg[line_ctrl_pkg::POS_MARK_INVERSION_ENABLE];
  wire [5:0] gain_ctrl =
    tx_build_out_gain_reg[line_ctrl_pkg::POS_GAIN_CTRL_MSB:line_ctrl_pkg::POS_GAIN_CTRL_LSB];
  wire auto_gain_sel = tx_build_out_gain_reg[line_ctrl_pkg::POS_AUTO_GAIN_SEL];

  // Mode decode
  wire mode_t1_e1 = (LINE_MODE == line_ctrl_pkg::MODE_T1) ||
                    (LINE_MODE == line_ctrl_pkg::MODE_E1);
  wire mode_cc = (LINE_MODE == line_ctrl_pkg::MODE_COMP_CLK);
  wire mode_6312 = (LINE_MODE == line_ctrl_pkg::MODE_SYNC_6312);

  // Derived controls
  wire atten_enable_next = mode_t1_e1 && !atten_disable;
  wire [7:0] atten_depth_next = atten_depth_sel ? line_ctrl_pkg::ATTEN_DEPTH_SHALLOW :
                                                  line_ctrl_pkg::ATTEN_DEPTH_DEEP;
  wire short_limit_next = !short_limit_off && !mode_6312;
  wire cc_filter_next = cc_filter_bit && mode_cc;
  wire auto_gain_next = !auto_gain_sel;
  wire square_mode = custom_driver_sel && (build_out == 3'h0);
  wire open_drain = custom_driver_sel && (build_out != 3'h0);

  // Rising edges of violation and soft reset bits
  logic [1:0] rise_pulse; // [0] violation, [1] soft reset
  rise_detect #(.W(2)) u_rise (
    .CLK(CLK),
    .RST_N(RST_N),
    .level({line_soft_reset, insert_violation}),
    .pulse(rise_pulse)
  );

  // Transmit datapath state
  logic viol_armed_reg; // Violation waiting for a run of ones
  logic [1:0] ones_run_reg; // Consecutive ones seen
  logic last_mark_pos_reg; // Polarity of last mark
  logic alt_phase_reg; // Alternating pattern phase
  logic square_reg; // Square wave phase
  logic pos_reg; // Positive mark this bit
  logic neg_reg; // Negative mark this bit

  // Source bit: alternating wins over alarm, alarm over data
  wire src_bit = alt_pattern ? alt_phase_reg :
                 !tx_alarm_ones_n ? 1'b1 :
                 TX_DATA;
  wire [1:0] ones_run_inc = (ones_run_reg == line_ctrl_pkg::VIOLATION_RUN) ?
                            ones_run_reg : ones_run_reg + 2'h1;
  wire [1:0] ones_run_next = src_bit ? ones_run_inc : 2'h0;
  // Third or later one in a row carries the violation
  wire viol_fire = BIT_TICK && viol_armed_reg && src_bit &&
                   (ones_run_next == line_ctrl_pkg::VIOLATION_RUN);
  // Violation repeats last polarity, normal marks alternate
  wire mark_pos = viol_fire ? last_mark_pos_reg : !last_mark_pos_reg;
  // Violation not supported in composite clock or 6312 kHz modes
  wire viol_arm = rise_pulse[0] && mode_t1_e1;

  // Register writes; readback of all eight bits
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      line_cfg_one_reg <= line_ctrl_pkg::RST_LINE_CFG_ONE;
      line_cfg_two_reg <= line_ctrl_pkg::RST_LINE_CFG_TWO;
      line_cfg_three_reg <= line_ctrl_pkg::RST_LINE_CFG_THREE;
      tx_build_out_gain_reg <= line_ctrl_pkg::RST_TX_BUILD_OUT_GAIN;
    end else if (WR_EN) begin
      if (sel_one) line_cfg_one_reg <= WDATA;
      if (sel_two) line_cfg_two_reg <= WDATA;
      if (sel_three) line_cfg_three_reg <= WDATA;
      if (sel_gain) tx_build_out_gain_reg <= WDATA;
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
      RD_VALID <= 1'b0;
    end else begin
      RD_VALID <= RD_EN;
      if (RD_EN) RDATA <= rd_mux;
    end
  end

  // Decoded control outputs, registered
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ATTEN_ENABLE <= 1'b0;
      ATTEN_DEPTH <= line_ctrl_pkg::ATTEN_DEPTH_DEEP;
      ATTEN_ON_TX <= 1'b0;
      EQ_GAIN_LIMIT <= 1'b0;
      BUILD_OUT <= 3'h0;
      AUTO_GAIN_ON <= 1'b1;
      GAIN_LEVEL <= 6'h00;
      SHORT_LIMIT_EN <= 1'b1;
      CC_FILTER_EN <= 1'b0;
      PLL_T1_EN <= 1'b0;
      PLL_E1_EN <= 1'b0;
      MONITOR_BOOST <= 2'h0;
      CMI_EN <= 1'b0;
      CMI_INV <= 1'b0;
    end else begin
      ATTEN_ENABLE <= atten_enable_next;
      ATTEN_DEPTH <= atten_depth_next;
      ATTEN_ON_TX <= atten_side_sel;
      EQ_GAIN_LIMIT <= eq_gain_limit;
      BUILD_OUT <= build_out;
      AUTO_GAIN_ON <= auto_gain_next;
      // Gain held at zero under automatic gain, bits are ignored
      GAIN_LEVEL <= auto_gain_next ? 6'h00 : gain_ctrl;
      SHORT_LIMIT_EN <= short_limit_next;
      CC_FILTER_EN <= cc_filter_next;
      PLL_T1_EN <= atten_clk_sel_lo;
      PLL_E1_EN <= atten_clk_sel_hi;
      MONITOR_BOOST <= monitor_gain;
      CMI_EN <= cmi_en_bit;
      CMI_INV <= cmi_inv_bit;
    end
  end

  // Soft reset pulse; one per rising edge only
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LINE_RESET_PULSE <= 1'b0;
    end else begin
      LINE_RESET_PULSE <= rise_pulse[1];
    end
  end

  // Violation arm; a new rise wins over a consumption
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      viol_armed_reg <= 1'b0;
    end else if (viol_arm) begin
      viol_armed_reg <= 1'b1;
    end else if (viol_fire) begin
      viol_armed_reg <= 1'b0;
    end
  end

  // Bit-rate encoder: marks alternate, zeros idle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ones_run_reg <= 2'h0;
      last_mark_pos_reg <= 1'b0;
      alt_phase_reg <= 1'b1;
      square_reg <= 1'b0;
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else if (BIT_TICK) begin
      ones_run_reg <= ones_run_next;
      alt_phase_reg <= !alt_phase_reg;
      square_reg <= !square_reg;
      if (src_bit) begin
        last_mark_pos_reg <= mark_pos;
        pos_reg <= mark_pos;
        neg_reg <= !mark_pos;
      end else begin
        pos_reg <= 1'b0;
        neg_reg <= 1'b0;
      end
    end
  end

  // Line pin drive; power-down tristates both pins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_LINE_POS_O <= 1'b0;
      TX_LINE_NEG_O <= 1'b0;
      TX_LINE_POS_OE_N <= 1'b1;
      TX_LINE_NEG_OE_N <= 1'b1;
    end else if (!power_n) begin
      TX_LINE_POS_O <= 1'b0;
      TX_LINE_NEG_O <= 1'b0;
      TX_LINE_POS_OE_N <= 1'b1;
      TX_LINE_NEG_OE_N <= 1'b1;
    end else if (square_mode) begin
      TX_LINE_POS_O <= square_reg;
      TX_LINE_NEG_O <= !square_reg;
      TX_LINE_POS_OE_N <= 1'b0;
      TX_LINE_NEG_OE_N <= 1'b0;
    end else if (open_drain) begin
      // Open drain pulls low on a mark, floats otherwise
      TX_LINE_POS_O <= 1'b0;
      TX_LINE_NEG_O <= 1'b0;
      TX_LINE_POS_OE_N <= !pos_reg;
      TX_LINE_NEG_OE_N <= !neg_reg;
    end else begin
      TX_LINE_POS_O <= pos_reg;
      TX_LINE_NEG_O <= neg_reg;
      TX_LINE_POS_OE_N <= 1'b0;
      TX_LINE_NEG_OE_N <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_power_tristate: assert property (
    !power_n |=> TX_LINE_POS_OE_N && TX_LINE_NEG_OE_N)
    else $error("line pins driven while powered down");
  a_atten_path: assert property (
    1'b1 |=> ATTEN_ENABLE == (!$past(atten_disable) && ($past(LINE_MODE) < 2'd2)))
    else $error("attenuator enable wrong");
  a_depth_deep: assert property (
    !atten_depth_sel |=> ATTEN_DEPTH == 8'h80)
    else $error("deep depth not 128");
  a_depth_sel: assert property (
    atten_depth_sel |=> ATTEN_DEPTH == 8'h20)
    else $error("shallow depth not 32");
  a_gain_ignored: assert property (
    !auto_gain_sel |=> AUTO_GAIN_ON && GAIN_LEVEL == 6'h00)
    else $error("gain bits not ignored under AGC");
  a_limit_6312: assert property (
    mode_6312 |=> !SHORT_LIMIT_EN)
    else $error("limiter active in 6312 mode");
  a_filter_mode: assert property (
    !mode_cc |=> !CC_FILTER_EN)
    else $error("filter on outside composite mode");
  a_reset_pulse: assert property (
    WR_EN && sel_two && WDATA[6] && !line_soft_reset |=> ##2 LINE_RESET_PULSE)
    else $error("soft reset pulse missing");
  a_reset_single: assert property (
    LINE_RESET_PULSE |=> !LINE_RESET_PULSE)
    else $error("soft reset pulse repeated");
  a_viol_once: assert property (
    viol_fire && !viol_arm |=> !viol_armed_reg)
    else $error("violation arm not consumed");
  a_readback: assert property (
    WR_EN && sel_one ##1 RD_EN && sel_one && !WR_EN |=> RD_VALID && RDATA == $past(WDATA, 2))
    else $error("readback mismatch");
  a_alt_toggle: assert property (
    alt_pattern && BIT_TICK |=> alt_phase_reg != $past(alt_phase_reg))
    else $error("alternating phase stuck");
  // Alarm forces a mark on every bit unless the pattern overrides it
  a_alarm_ones: assert property (
    BIT_TICK && !tx_alarm_ones_n && !alt_pattern |=> pos_reg != neg_reg)
    else $error("alarm bit not sent as mark");
  a_square_wave: assert property (
    square_mode && power_n |=> TX_LINE_NEG_O != TX_LINE_POS_O && !TX_LINE_POS_OE_N)
    else $error("square wave pins not complementary");
  a_power_drive: assert property (
    power_n && !custom_driver_sel |=> !TX_LINE_POS_OE_N && !TX_LINE_NEG_OE_N)
    else $error("line pins not driven in normal mode");
  // A rise outside T1 or E1 must leave the violation unarmed
  a_viol_mode: assert property (
    rise_pulse[0] && !mode_t1_e1 && !viol_armed_reg |=> !viol_armed_reg)
    else $error("violation armed in unsupported mode");

  c_violation: cover property (viol_fire);
  c_soft_reset: cover property (LINE_RESET_PULSE);
  c_open_drain: cover property (open_drain && power_n && BIT_TICK);
  c_square: cover property (square_mode && power_n);

endmodule

// >>> pkg/line_ctrl_pkg.sv
package line_ctrl_pkg;

  // Register offsets on the control port
  localparam logic [7:0] OFS_LINE_CFG_ONE = 8'h30;
  localparam logic [7:0] OFS_LINE_CFG_TWO = 8'h31;
  localparam logic [7:0] OFS_LINE_CFG_THREE = 8'h32;
  localparam logic [7:0] OFS_TX_BUILD_OUT_GAIN = 8'h34;

  // Reset values, all zero in software-controlled mode
  localparam logic [7:0] RST_LINE_CFG_ONE = 8'h00;
  localparam logic [7:0] RST_LINE_CFG_TWO = 8'h00;
  localparam logic [7:0] RST_LINE_CFG_THREE = 8'h00;
  localparam logic [7:0] RST_TX_BUILD_OUT_GAIN = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // line_cfg_one fields
  localparam int POS_TX_POWER_DOWN_N = 0;
  localparam int POS_ATTEN_DISABLE = 1;
  localparam int POS_ATTEN_DEPTH_SEL = 2;
  localparam int POS_ATTEN_SIDE_SEL = 3;
  localparam int POS_EQ_GAIN_LIMIT = 4;
  localparam int POS_BUILD_OUT_LSB = 5;
  localparam int POS_BUILD_OUT_MSB = 7;

  // line_cfg_two fields
  localparam int POS_CUSTOM_DRIVER_SEL = 0;
  localparam int POS_SHORT_LIMIT_OFF = 1;
  localparam int POS_RX_COMP_CLK_FILTER_EN = 2;
  localparam int POS_ATTEN_CLK_SEL_LO = 3;
  localparam int POS_TX_ALARM_ONES_N = 4;
  localparam int POS_INSERT_VIOLATION = 5;
  localparam int POS_LINE_SOFT_RESET = 6;
  localparam int POS_ATTEN_CLK_SEL_HI = 7;

  // line_cfg_three fields
  localparam int POS_TX_ALTERNATING_PATTERN = 0;
  localparam int POS_MONITOR_GAIN_LO = 3;
  localparam int POS_MONITOR_GAIN_HI = 4;
  localparam int POS_MARK_INVERSION_INVERT = 6;
  localparam int POS_MARK_INVERSION_ENABLE = 7;

  // tx_build_out_gain fields
  localparam int POS_GAIN_CTRL_LSB = 0;
  localparam int POS_GAIN_CTRL_MSB = 5;
  localparam int POS_AUTO_GAIN_SEL = 6;

  // Attenuator elastic store depths in bits
  localparam logic [7:0] ATTEN_DEPTH_DEEP = 8'h80;
  localparam logic [7:0] ATTEN_DEPTH_SHALLOW = 8'h20;

  // Ones in a row at which an armed violation fires
  localparam logic [1:0] VIOLATION_RUN = 2'h3;

  // Line network mode
  typedef enum logic [1:0] {
    MODE_T1 = 2'b00,
    MODE_E1 = 2'b01,
    MODE_COMP_CLK = 2'b10,
    MODE_SYNC_6312 = 2'b11
  } line_mode_t;

endpackage

// >>> rtl/rise_detect.sv
`timescale 1ns/1ps
// Registered zero-to-one detector, one pulse per rising level
module rise_detect #(
  parameter int W = 2
) (
  input wire logic CLK, // System clock
  input wire logic RST_N, // Async reset, active low
  input wire logic [W-1:0] level, // Levels to watch
  output logic [W-1:0] pulse // One-cycle pulse per rise
);

  logic [W-1:0] prev_reg; // Last sampled level

  // Level held at reset as zero, so a bit already set at release fires once
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prev_reg <= '0;
      pulse <= '0;
    end else begin
      prev_reg <= level;
      pulse <= level & ~prev_reg;
    end
  end

endmodule

// >>> dv/line_model.sv
`timescale 1ns/1ps
// Far end of the line through the transformer: decodes marks per bit period
module line_model (
  input wire logic clk, // System clock
  input wire logic take, // Bit sample strobe from the bench
  input wire logic pos_o, // Positive pin value
  input wire logic pos_oe_n, // Positive pin enable, low drives
  input wire logic neg_o, // Negative pin value
  input wire logic neg_oe_n, // Negative pin enable, low drives
  output int marks, // Marks seen so far
  output int viols, // Marks that repeat the previous polarity
  output logic floating // Both wires released at the last sample
);
  wire tip; // Resolved positive wire
  wire ring; // Resolved negative wire
  logic last_neg = 1'b0; // Polarity of the previous mark
  logic prev_ok = 1'b0; // A previous mark is known
  // No pull on a transformer winding, so a released wire floats
  assign tip = pos_oe_n ? 1'bz : pos_o;
  assign ring = neg_oe_n ? 1'bz : neg_o;
  initial begin
    marks = 0;
    viols = 0;
    floating = 1'b0;
  end
  // One decode per strobe; polarity history is lost while released
  always @(posedge clk) begin
    if (take) begin
      floating <= (tip === 1'bz) && (ring === 1'bz);
      if ((tip === 1'bz) && (ring === 1'bz)) begin
        prev_ok <= 1'b0;
      end else if ((tip ^ ring) === 1'b1) begin // Mark on one wire only
        marks <= marks + 1;
        if (prev_ok && (ring === last_neg)) begin
          viols <= viols + 1;
        end
        last_neg <= ring;
        prev_ok <= 1'b1;
      end
    end
  end
endmodule

// >>> dv/line_ctrl_regs_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the line-interface control registers
module line_ctrl_regs_tb;
  logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0; // Bench-driven controls
  logic bit_tick = 1'b0, tx_data = 1'b0, take = 1'b0; // Transmit stimulus
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, atten_depth, rv, sh [8]; // Bus and shadow
  logic [1:0] line_mode = 2'b00, monitor_boost; // Network mode and boost
  logic rd_valid, pos_o, pos_oe_n, neg_o, neg_oe_n, atten_enable, atten_on_tx, eq_gain_limit;
  logic auto_gain_on, short_limit_en, cc_filter_en, pll_t1_en, pll_e1_en, cmi_en, cmi_inv;
  logic line_reset_pulse, floating, p; // Pulse, line state, scratch
  logic [2:0] build_out; // Build-out code seen
  logic [5:0] gain_level; // Fixed gain seen
  logic [28:0] ev; // Expected derived outputs
  logic [39:0] corner [4] = '{40'h01_a1_80_d8_68, 40'h00_1f_0e_10_66,
    40'h02_02_06_08_00, 40'h03_00_00_00_00}; // Mode, three configs, gain
  int bad_count = 0, checks_done = 0, pulses = 0, marks, viols, i, n, p0; // Counters
  wire [28:0] seen_out = {atten_enable, atten_depth, atten_on_tx, eq_gain_limit, build_out,
    auto_gain_on, gain_level, short_limit_en, cc_filter_en, pll_t1_en, pll_e1_en,
    monitor_boost, cmi_en, cmi_inv}; // All derived outputs in one word

  line_ctrl_regs line_ctrl_regs_i (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WR_EN(wr_en),
    .RD_EN(rd_en), .WDATA(wdata), .RDATA(rdata), .RD_VALID(rd_valid), .LINE_MODE(line_mode),
    .BIT_TICK(bit_tick), .TX_DATA(tx_data), .TX_LINE_POS_O(pos_o),
    .TX_LINE_POS_OE_N(pos_oe_n), .TX_LINE_NEG_O(neg_o), .TX_LINE_NEG_OE_N(neg_oe_n),
    .ATTEN_ENABLE(atten_enable), .ATTEN_DEPTH(atten_depth), .ATTEN_ON_TX(atten_on_tx),
    .EQ_GAIN_LIMIT(eq_gain_limit), .BUILD_OUT(build_out), .AUTO_GAIN_ON(auto_gain_on),
    .GAIN_LEVEL(gain_level), .SHORT_LIMIT_EN(short_limit_en), .CC_FILTER_EN(cc_filter_en),
    .PLL_T1_EN(pll_t1_en), .PLL_E1_EN(pll_e1_en), .MONITOR_BOOST(monitor_boost),
    .CMI_EN(cmi_en), .CMI_INV(cmi_inv), .LINE_RESET_PULSE(line_reset_pulse));

  line_model line_model_i (.clk(clk), .take(take), .pos_o(pos_o), .pos_oe_n(pos_oe_n),
    .neg_o(neg_o), .neg_oe_n(neg_oe_n), .marks(marks), .viols(viols), .floating(floating));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Count recovery reset pulses as the design raises them
  always @(posedge clk) begin
    if (line_reset_pulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  // Compare and count; any difference is reported at once
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Single exit point of the run
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Write strobe for one cycle; shadow follows mapped offsets only
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    if (a inside {line_ctrl_pkg::OFS_LINE_CFG_ONE, line_ctrl_pkg::OFS_LINE_CFG_TWO,
        line_ctrl_pkg::OFS_LINE_CFG_THREE, line_ctrl_pkg::OFS_TX_BUILD_OUT_GAIN}) begin
      sh[a[2:0]] = d;
    end
  endtask

  // Read strobe, then a bounded wait for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int w;
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    w = 0;
    while (rd_valid !== 1'b1) begin
      w++;
      if (w > 4) begin
        bad_count++;
        end_of_test();
      end
      @(negedge clk);
    end
    d = rdata;
  endtask

  // Read back all four registers against the shadow
  task automatic chk_regs();
    for (int k = 0; k < 5; k++) begin
      if (k != 3) begin
        rd(8'h30 + 8'(k), rv);
        check("readback", rv, sh[k]);
      end
    end
  endtask

  // Expected derived outputs from register contents and mode
  function automatic logic [28:0] exp_out(input logic [1:0] m, input logic [7:0] c1,
      input logic [7:0] c2, input logic [7:0] c3, input logic [7:0] g);
    return {m < 2'd2 && !c1[1], c1[2] ? line_ctrl_pkg::ATTEN_DEPTH_SHALLOW :
      line_ctrl_pkg::ATTEN_DEPTH_DEEP, c1[3], c1[4], c1[7:5], !g[6], g[6] ? g[5:0] : 6'h00,
      !c2[1] && m != line_ctrl_pkg::MODE_SYNC_6312, c2[2] && m == line_ctrl_pkg::MODE_COMP_CLK,
      c2[3], c2[7], c3[4:3], c3[7], c3[6]};
  endfunction

  // One bit period: tick, two edges to the pins, then let the line sample
  task automatic send(input logic d);
    @(negedge clk);
    bit_tick = 1'b1;
    tx_data = d;
    @(negedge clk);
    bit_tick = 1'b0;
    @(negedge clk);
    @(negedge clk);
    take = 1'b1;
    @(negedge clk);
    take = 1'b0;
  endtask

  // Run of equal bits, then mark and polarity-fault counts
  task automatic tx_run(input logic d, input int cnt, input int em, input int ev);
    int m0;
    int v0;
    m0 = marks;
    v0 = viols;
    repeat (cnt) send(d);
    check("marks", marks - m0, em);
    check("violations", viols - v0, ev);
  endtask

  // Hang guard well inside the cycle budget
  initial begin
    #900000;
    bad_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    sh = '{default: 8'h00};
    void'($urandom(32'h4b946512));
    repeat (20) @(posedge clk);
    @(negedge clk);
    check("reset_oe_n", {pos_oe_n, neg_oe_n}, 2'b11);
    check("reset_depth", atten_depth, line_ctrl_pkg::ATTEN_DEPTH_DEEP);
    rst_n = 1'b1;
    chk_regs();
    // Corner table first, random settings after; gain bit 7 always written zero
    for (i = 0; i < 40; i++) begin
      @(negedge clk);
      line_mode = i < 4 ? corner[i][33:32] : 2'($urandom);
      wr(8'h30, i < 4 ? corner[i][31:24] : 8'($urandom));
      wr(8'h31, i < 4 ? corner[i][23:16] : 8'($urandom));
      wr(8'h32, i < 4 ? corner[i][15:8] : 8'($urandom));
      wr(8'h34, i < 4 ? corner[i][7:0] : 8'($urandom) & 8'h7f);
      chk_regs();
      ev = exp_out(line_mode, sh[0], sh[1], sh[2], sh[4]);
      check("derived", seen_out, ev);
    end
    // Unmapped offset: reads zero, write lost
    wr(8'h33, 8'hff);
    rd(8'h33, rv);
    check("unmapped", rv, line_ctrl_pkg::RD_UNMAPPED);
    // Write then read in the very next cycle must see the new value
    @(negedge clk);
    addr = line_ctrl_pkg::OFS_LINE_CFG_ONE;
    wdata = 8'h5a;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    check("back_to_back", {rd_valid, rdata}, {1'b1, 8'h5a});
    sh[0] = 8'h5a;
    chk_regs();
    // Soft reset fires once per rise only
    wr(8'h31, 8'h00);
    p0 = pulses;
    wr(8'h31, 8'h40);
    repeat (4) @(negedge clk);
    wr(8'h31, 8'h40);
    repeat (4) @(negedge clk);
    check("reset_pulses", pulses - p0, 1);
    wr(8'h31, 8'h00);
    wr(8'h31, 8'h40);
    repeat (4) @(negedge clk);
    check("reset_pulses", pulses - p0, 2);
    // Mid-run reset: line pins tristated, registers back to zero
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    check("reset_oe_n", {pos_oe_n, neg_oe_n}, 2'b11);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    sh = '{default: 8'h00};
    chk_regs();
    // Transmit path: power-down, data, alarm ones, alternating pattern and violation in T1, then composite clock
    line_mode = line_ctrl_pkg::MODE_T1;
    wr(8'h30, 8'h00);
    wr(8'h31, 8'h10);
    wr(8'h32, 8'h00);
    send(1'b1);
    check("powered_down", floating, 1'b1);
    wr(8'h30, 8'h01);
    p0 = marks;
    n = 0;
    for (i = 0; i < 12; i++) begin
      p = 1'($urandom);
      n += p;
      send(p);
    end
    check("random_marks", marks - p0, n);
    tx_run(1'b0, 2, 0, 0);
    wr(8'h31, 8'h00);
    tx_run(1'b0, 4, 4, 0);
    wr(8'h32, 8'h01);
    tx_run(1'b0, 6, 3, 0);
    wr(8'h32, 8'h00);
    wr(8'h31, 8'h10);
    wr(8'h31, 8'h30);
    tx_run(1'b1, 6, 6, 1);
    tx_run(1'b1, 6, 6, 0);
    line_mode = line_ctrl_pkg::MODE_COMP_CLK;
    wr(8'h31, 8'h10);
    wr(8'h31, 8'h30);
    tx_run(1'b1, 6, 6, 0);
    // Custom driver: square wave, then open drain
    line_mode = line_ctrl_pkg::MODE_T1;
    wr(8'h31, 8'h11);
    send(1'b0);
    p = pos_o;
    check("square_neg", neg_o, !p);
    send(1'b0);
    check("square_pos", pos_o, !p);
    wr(8'h30, 8'h21);
    send(1'b1);
    check("drain_level", {pos_o, neg_o}, 2'b00);
    check("drain_one_pin", pos_oe_n ^ neg_oe_n, 1'b1);
    send(1'b0);
    check("drain_release", {pos_oe_n, neg_oe_n}, 2'b11);
    end_of_test();
  end
endmodule
